// ---- rtl/acsr_register_bank.v ----
// Converter register bank: two-word writes, readback select, status word and correction path
`timescale 1ns/1ps
`default_nettype none
`include "acsr_defines.vh"
module acsr_register_bank #(
  parameter [1:0] PRODUCT_CODE = 2'h1,  // Arbitrary value
  parameter       DATA_W       = 16
) (
  input  wire              clk,
  input  wire              arst_n,
  input  wire              wr_stb,
  input  wire [15:0]       wr_data,
  input  wire              rd_stb,
  output reg  [15:0]       rd_data,
  input  wire [2:0]        chip_instance_id,
  input  wire              result_valid_flag,
  input  wire              download_checksum_match,
  input  wire              filter_checksum_match,
  input  wire              user_filter_active,
  input  wire              stage1_valid,
  input  wire [DATA_W-1:0] stage1_data,
  input  wire              mod_valid,
  input  wire              mod_over_full,
  input  wire              res_in_valid,
  input  wire [DATA_W-1:0] res_in_data,
  output reg               res_out_valid,
  output reg  [DATA_W-1:0] res_out_data,
  output wire              clock_halving_select,
  output wire              chip_power_off,
  output wire              reduced_power_select,
  output wire              input_amp_power_off,
  output wire              third_stage_enable,
  output wire [2:0]        rate_divide_select
);
  reg  [15:0] ctrl1_reg, ctrl2_reg, offset_reg, gain_reg, thresh_reg;
  reg  [15:0] addr_reg;
  reg         have_addr_reg;
  reg  [2:0]  id_meta_reg;  // First stage of the die id synchroniser
  reg  [2:0]  id_sync_reg;  // Second stage, the only one logic reads
  reg  [3:0]  rd_sel_reg;
  reg  [2:0]  full_cnt_reg;
  reg         ovr_reg;
  reg  [15:0] stat_word;
  reg  [15:0] mag_in;
  reg  [31:0] prod;
  reg  [17:0] sum;

  // Absolute value of a two's-complement sample
  function [15:0] acsr_abs;
    input [15:0] v;
    begin
      acsr_abs = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  assign clock_halving_select = ~ctrl2_reg[`ACSR_C2_CLKHALF];
  assign chip_power_off       = ctrl2_reg[`ACSR_C2_PWROFF];
  assign reduced_power_select = ctrl2_reg[`ACSR_C2_LOWPWR];
  assign input_amp_power_off  = ctrl2_reg[`ACSR_C2_AMPOFF];
  assign third_stage_enable   = ctrl1_reg[`ACSR_C1_BYPF3];
  assign rate_divide_select   = ctrl1_reg[2:0];

  // Status word assembly
  always @* begin
    stat_word        = 16'h0000;
    stat_word[15:14] = PRODUCT_CODE;
    stat_word[13:11] = id_sync_reg;
    stat_word[10]    = result_valid_flag;
    stat_word[9]     = ctrl2_reg[`ACSR_C2_LOWPWR];
    stat_word[8]     = ovr_reg;
    stat_word[7]     = download_checksum_match;
    stat_word[6]     = filter_checksum_match;
    stat_word[5]     = user_filter_active;
    stat_word[4]     = ctrl1_reg[`ACSR_C1_BYPF3];
    stat_word[3]     = 1'b1;
    stat_word[2:0]   = ctrl1_reg[2:0];
  end

  // Gain then offset correction; 18-bit sum keeps full-scale gain from wrapping
  always @* begin
    prod = $signed(res_in_data) * $signed({1'b0, gain_reg});
    sum  = {prod[31], prod[31:15]} + {{2{offset_reg[15]}}, offset_reg};
    mag_in = acsr_abs(stage1_data);
  end

  // Two-word writes, readback select and register storage
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl1_reg     <= `ACSR_RST_CTRL1;
      ctrl2_reg     <= `ACSR_RST_CTRL2;
      offset_reg    <= `ACSR_RST_OFFSET;
      gain_reg      <= `ACSR_RST_GAIN;
      thresh_reg    <= `ACSR_RST_THRESH;
      addr_reg      <= 16'h0000;
      have_addr_reg <= 1'b0;
      rd_sel_reg    <= 4'h0;
      rd_data       <= 16'h0000;
      id_meta_reg   <= 3'h0;
      id_sync_reg   <= 3'h0;
    end else begin
      // Die id comes from pins, so it passes two flip-flops first
      id_meta_reg <= chip_instance_id;
      id_sync_reg <= id_meta_reg;
      if (wr_stb) begin
        have_addr_reg <= ~have_addr_reg;
        if (!have_addr_reg) begin
          addr_reg <= wr_data;
        end else begin
          case (addr_reg)
            `ACSR_ADDR_CTRL1: begin
              ctrl1_reg  <= {7'h00, wr_data[8:0]};  // Bits 15:9 self clear
              rd_sel_reg <= wr_data[14:11];
            end
            `ACSR_ADDR_CTRL2:  ctrl2_reg  <= {10'h000, wr_data[5:0]};
            `ACSR_ADDR_OFFSET: offset_reg <= wr_data;
            `ACSR_ADDR_GAIN:   gain_reg   <= wr_data;
            `ACSR_ADDR_THRESH: thresh_reg <= wr_data;
            default: ;
          endcase
        end
      end
      if (rd_stb) begin
        rd_sel_reg <= 4'h0;
        if (rd_sel_reg[`ACSR_C1_RDSTAT-11])      rd_data <= stat_word;
        else if (rd_sel_reg[`ACSR_C1_RDOFF-11])  rd_data <= offset_reg;
        else if (rd_sel_reg[`ACSR_C1_RDGAIN-11]) rd_data <= gain_reg;
        else if (rd_sel_reg[`ACSR_C1_RDOVR-11])  rd_data <= thresh_reg;
        else                                     rd_data <= res_out_data;
      end
    end
  end

  // Overrange detection on first-stage output and modulator full scale
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_cnt_reg <= 3'h0;
      ovr_reg      <= 1'b0;
    end else begin
      if (mod_valid) begin
        if (!mod_over_full)
          full_cnt_reg <= 3'h0;
        else if (full_cnt_reg != `ACSR_FULL_RUN + 3'h1)
          full_cnt_reg <= full_cnt_reg + 3'h1;
      end
      if (mod_valid && mod_over_full && full_cnt_reg >= `ACSR_FULL_RUN)
        ovr_reg <= 1'b1;
      else if (stage1_valid)
        ovr_reg <= ({mag_in, 1'b0} > {1'b0, thresh_reg});
    end
  end

  // Corrected result register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_out_valid <= 1'b0;
      res_out_data  <= 16'h0000;
    end else begin
      res_out_valid <= res_in_valid;
      if (res_in_valid) begin
        if (sum[17:15] != 3'b000 && sum[17:15] != 3'b111)
          res_out_data <= sum[17] ? 16'h8000 : 16'h7fff;
        else
          res_out_data <= sum[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- rtl/acsr_defines.vh ----
// Register offsets, field positions, reset values and timing counts of the converter register bank
`ifndef ACSR_DEFINES_VH
`define ACSR_DEFINES_VH
`define ACSR_ADDR_CTRL1      16'h0001
`define ACSR_ADDR_CTRL2      16'h0002
`define ACSR_ADDR_OFFSET     16'h0003
`define ACSR_ADDR_GAIN       16'h0004
`define ACSR_ADDR_THRESH     16'h0005
`define ACSR_RST_CTRL1       16'h001a
`define ACSR_RST_CTRL2       16'h009b
`define ACSR_RST_OFFSET      16'h0000
`define ACSR_RST_GAIN        16'ha000
`define ACSR_RST_THRESH      16'hcccc
`define ACSR_C2_CLKHALF      5
`define ACSR_C2_PWROFF       3
`define ACSR_C2_LOWPWR       2
`define ACSR_C2_AMPOFF       0
`define ACSR_C1_RDOVR        14
`define ACSR_C1_RDGAIN       13
`define ACSR_C1_RDOFF        12
`define ACSR_C1_RDSTAT       11
`define ACSR_C1_BYPF3        4
`define ACSR_FULL_RUN        3'h4
`endif

// ---- test/acsr_register_bank_sva.sv ----
// Port assertions for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module acsr_sva (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic        clock_halving_select,
  input wire logic        chip_power_off,
  input wire logic        reduced_power_select,
  input wire logic        input_amp_power_off,
  input wire logic        third_stage_enable,
  input wire logic [15:0] wr_data,
  input wire logic [15:0] rd_data,
  input wire logic [2:0]  rate_divide_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic        ph_reg;
  logic [15:0] ad_reg;
  wire  [3:0]  c2o = {clock_halving_select, chip_power_off, reduced_power_select, input_amp_power_off};
  wire         dw = wr_stb && ph_reg;
  wire         c1 = dw && ad_reg == 16'h0001;
  wire         c2 = dw && ad_reg == 16'h0002;
  // Word phase and latched address of two-word writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= 1'b0;
      ad_reg <= 16'h0000;
    end else if (wr_stb) begin
      ph_reg <= ~ph_reg;
      ad_reg <= ph_reg ? ad_reg : wr_data;
    end
  end
  property p_cd; c2 |=> c2o[3] == !$past(wr_data[5]); endproperty
  a_cd: assert property (p_cd) else $error("clock select");
  property p_pd; c2 |=> c2o[2] == $past(wr_data[3]); endproperty
  a_pd: assert property (p_pd) else $error("power off");
  property p_lp; c2 |=> c2o[1] == $past(wr_data[2]); endproperty
  a_lp: assert property (p_lp) else $error("low power");
  property p_amp; c2 |=> c2o[0] == $past(wr_data[0]); endproperty
  a_amp: assert property (p_amp) else $error("amp off");
  property p_dec;
    c1 |=> {third_stage_enable, rate_divide_select} == {$past(wr_data[4]), $past(wr_data[2:0])};
  endproperty
  a_dec: assert property (p_dec) else $error("rate code");
  property p_keep; !dw |=> $stable(c2o); endproperty
  a_keep: assert property (p_keep) else $error("control moved");
  property p_rd; !rd_stb |=> $stable(rd_data); endproperty
  a_rd: assert property (p_rd) else $error("read moved");
  property p_unm; dw && ad_reg > 16'h0005 |=> c2o == $past(c2o); endproperty
  a_unm: assert property (p_unm) else $error("unmapped write");
  cover property (c2);
  cover property (c1);
  cover property (rd_stb);
endmodule
bind acsr_register_bank acsr_sva u_sva (.*);
`default_nettype wire

// ---- test/acsr_host_model.sv ----
// Host bus model: two-word writes and strobed reads
`timescale 1ns/1ps
`default_nettype none
module acsr_host (
  input  wire logic        clk,
  output var  logic        wr_stb = 1'b0,
  output var  logic [15:0] wr_data = 16'h0000,
  output var  logic        rd_stb = 1'b0,
  input  wire logic [15:0] rd_data
);
  // Address word then data word under one held strobe
  task automatic wr(input logic [15:0] a, d);
    @(negedge clk) wr_stb = 1'b1;
    wr_data = a;
    @(negedge clk) wr_data = d;
    @(negedge clk) wr_stb = 1'b0;
    wr_data = ~d; // Released bus shows no stale word
  endtask
  // One readback select per control write, then the read
  task automatic rd_sel(input int b, output logic [15:0] v);
    wr(16'h0001, 16'h0019 | (16'h0001 << b));
    @(negedge clk) rd_stb = 1'b1;
    @(negedge clk) rd_stb = 1'b0;
    v = rd_data;
  endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, arst_n = 1'b0, res_in_valid = 1'b0, wr_stb, rd_stb, res_out_valid;
  logic        clock_halving_select, chip_power_off, reduced_power_select, input_amp_power_off, third_stage_enable;
  logic        result_valid_flag = 1'b1, download_checksum_match = 1'b1;
  logic        filter_checksum_match = 1'b0, user_filter_active = 1'b1;
  logic        stage1_valid = 1'b0, mod_valid = 1'b0, mod_over_full = 1'b0;
  logic [15:0] stage1_data = 16'h0000;
  logic [2:0]  rate_divide_select;
  logic [15:0] wr_data, rd_data, res_out_data, v, res_in_data = 16'h1000;
  int          bad_count = 0, comparisons = 0;
  wire  [3:0]  c2o = {clock_halving_select, chip_power_off, reduced_power_select, input_amp_power_off};
  acsr_host host (.*);
  acsr_register_bank uut (.chip_instance_id(3'h5), .*);
  // Count a compare and report a difference
  task automatic chk(input logic [15:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts, verdict and stop
  task automatic test_done;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One first-stage sample at the falling edge
  task automatic stage1(input logic [15:0] d);
    @(negedge clk) stage1_valid = 1'b1;
    stage1_data = d;
    @(negedge clk) stage1_valid = 1'b0;
  endtask
  // 200 MHz clock
  initial forever #2.5 clk = ~clk;
  // Watchdog far beyond the run length
  initial begin
    #20000;
    bad_count++;
    test_done;
  end
  // Test sequence
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    chk(c2o, 16'hd);
    for (int i = 12; i < 15; i++) begin
      host.rd_sel(i, v);
      chk(v, i == 12 ? 16'h0000 : i == 13 ? 16'ha000 : 16'hcccc);
    end
    $display("test defaults done");
    host.wr(16'h0002, 16'h0026);
    chk(c2o, 16'h2);
    host.rd_sel(11, v);
    chk(v, 16'h6eb9);
    chk({third_stage_enable, rate_divide_select}, 16'h9);
    host.wr(16'h0002, 16'h000a);
    chk(c2o, 16'hc);
    host.wr(16'h0002, 16'h0003);
    chk(c2o, 16'h9);
    $display("test control done");
    host.wr(16'h0003, 16'h0010);
    host.wr(16'h0004, 16'h4000);
    host.wr(16'h0007, 16'hffff);
    host.rd_sel(12, v);
    chk(v, 16'h0010);
    @(negedge clk) res_in_valid = 1'b1;
    @(negedge clk) res_in_valid = 1'b0;
    chk({res_out_valid, res_out_data[14:0]}, 16'h8810);
    $display("test correction done");
    stage1(16'h7000);
    host.rd_sel(11, v);
    chk(v, 16'h6db9);
    host.wr(16'h0005, 16'hf000);
    stage1(16'h7000);
    host.rd_sel(11, v);
    chk(v, 16'h6cb9);
    host.rd_sel(14, v);
    chk(v, 16'hf000);
    @(negedge clk) mod_valid = 1'b1;
    mod_over_full = 1'b1;
    repeat (4) @(negedge clk);
    mod_valid = 1'b0;
    host.rd_sel(11, v);
    chk(v, 16'h6cb9);
    @(negedge clk) mod_valid = 1'b1;
    @(negedge clk) mod_valid = 1'b0;
    host.rd_sel(11, v);
    chk(v, 16'h6db9);
    $display("test overrange done");
    test_done;
  end
endmodule
`default_nettype wire
